// ==== rtl/chg_term_pkg.sv ====
// Package of constants and types for the charge termination control block
package chg_term_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;
   localparam logic [11:0] OFS_CHG_TIME = 12'h010;
   localparam logic [11:0] OFS_ELAPSED = 12'h014;
   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int CTRL_TIMED_BIT = 0;
   localparam int CTRL_DET_OPEN_BIT = 1;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_FAULT_BIT = 1;
   localparam int IRQ_RECHG_BIT = 2;
   localparam int IRQ_WIDTH = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int TERM_FILTER_US = 1500;
   localparam int TERM_FILTER_CYC = (CLK_HZ / 1_000_000) * TERM_FILTER_US;
   // 3 hours at 25 MHz, default; shortened in simulation
   localparam longint CHG_TIME_S = 10800;
   localparam logic [39:0] CHG_TIME_CYC = 40'(CHG_TIME_S * CLK_HZ);
   localparam int BLINK_HALF_CYC = 4_032_258;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {MODE_TIME, MODE_CURRENT, MODE_USER} mode_e;
   typedef enum logic [2:0] {ST_OFF, ST_CHECK, ST_CHARGE, ST_STANDBY,
      ST_FAULT} chg_state_e;
   typedef struct packed {
      logic current_above;
      logic cv_mode;
      logic trickle;
      logic bat_above_rechg;
   } analog_s;
endpackage

// ==== rtl/sync2.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(parameter int W = 1)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/term_filter.sv ====
// Termination filter counter for the low-current comparator
`timescale 1ns/1ps
`default_nettype none
module term_filter
   import chg_term_pkg::*;
#(parameter int COUNT = TERM_FILTER_CYC)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic below,
   output logic expired
);
   localparam int CW = $clog2(COUNT + 1);
   if (COUNT < 1)
   begin
      $error("term_filter COUNT must be at least 1");
   end
   logic [CW-1:0] cnt_q;
   wire logic hit = (cnt_q == CW'(COUNT));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_q <= '0;
      else if (!enable || !below)
         cnt_q <= '0;
      else if (!hit)
         cnt_q <= cnt_q + CW'(1);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         expired <= 1'b0;
      else
         expired <= enable && below && hit;
   end
endmodule
`default_nettype wire

// ==== rtl/charge_termination_control.sv ====
// Charge termination control with APB registers
//
// What this block does
// - Time mode: status low while current above threshold
// - Time mode: status released when timer expires
// - Detect open: status low until timer ends
// - Full time first, half on recharge
// - Timer-select ground: current termination, timer off
// - Stop after filtered low current, ignore dips
// - Current mode: status low while charging only
// - Timer-select supply: no internal termination
// - User mode: status like time mode
// - User mode: start charging without voltage check
// - Start: standby if battery above recharge level
// - Standby recharge at half time, not user
// - Enable pin forces shutdown in every state
// - Time mode: long trickle gives fault with blinking status
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module charge_termination_control
   import chg_term_pkg::*;
#(
   parameter logic [39:0] CHARGE_CYCLES = CHG_TIME_CYC,
   parameter int FILTER_CYCLES = TERM_FILTER_CYC,
   parameter int BLINK_CYCLES = BLINK_HALF_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic charger_enable_pin,
   input wire logic timer_sel_gnd,
   input wire logic timer_sel_vcc,
   input wire analog_s analog_in,
   output logic charge_status_out_oe_n,
   output logic charge_status_out_o,
   output logic charging_on
);
   if (CHARGE_CYCLES < 40'd8)
   begin
      $error("CHARGE_CYCLES too small");
   end
   if (BLINK_CYCLES < 1)
   begin
      $error("BLINK_CYCLES must be positive");
   end
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [6:0] pins_s;
   // Enable pin inverted so the reset value reads as shutdown
   sync2 #(.W(7)) i_sync2
   (
      .pclk(pclk),
      .presetn(presetn),
      .d({~charger_enable_pin, timer_sel_gnd, timer_sel_vcc, analog_in}),
      .q(pins_s)
   );
   wire logic shutdown = !pins_s[6];
   wire logic sel_gnd = pins_s[5];
   wire logic sel_vcc = pins_s[4];
   analog_s ana;
   assign ana = analog_s'(pins_s[3:0]);
   // ****************************************
   // Mode select
   // ****************************************
   mode_e mode;
   assign mode = sel_vcc ? MODE_USER :
                 sel_gnd ? MODE_CURRENT : MODE_TIME;
   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] ctrl_q;
   logic [IRQ_WIDTH-1:0] irq_stat_q, irq_mask_q;
   logic [39:0] time_q;
   logic [39:0] elapsed_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q;
   wire logic access = psel && penable;
   wire logic wr = access && pwrite;
   wire logic hit_ctrl = (paddr == OFS_CTRL);
   wire logic hit_stat = (paddr == OFS_STATUS);
   wire logic hit_istat = (paddr == OFS_IRQ_STAT);
   wire logic hit_imask = (paddr == OFS_IRQ_MASK);
   wire logic hit_time = (paddr == OFS_CHG_TIME);
   wire logic hit_elap = (paddr == OFS_ELAPSED);
   wire logic mapped = hit_ctrl || hit_stat || hit_istat || hit_imask ||
                       hit_time || hit_elap;
   wire logic timed_cfg = ctrl_q[CTRL_TIMED_BIT];
   wire logic det_open = ctrl_q[CTRL_DET_OPEN_BIT];
   // ****************************************
   // Charge state machine
   // ****************************************
   chg_state_e state_q, state_d;
   logic recharge_q, recharge_d;
   logic [39:0] timer_q, timer_d;
   logic [39:0] trickle_q, trickle_d;
   logic filt_done;
   wire logic [39:0] full_t = time_q;
   wire logic [39:0] half_t = {1'b0, time_q[39:1]};
   wire logic [39:0] quarter_t = {2'b00, time_q[39:2]};
   wire logic use_timer = (mode == MODE_TIME) && timed_cfg;
   wire logic charging = (state_q == ST_CHARGE);
   wire logic [39:0] limit_t = recharge_q ? half_t : full_t;
   wire logic timer_done = use_timer && (timer_q >= limit_t);
   wire logic trickle_over = use_timer && (trickle_q >= quarter_t);
   term_filter #(.COUNT(FILTER_CYCLES)) i_term_filter
   (
      .pclk(pclk),
      .presetn(presetn),
      .enable(charging && mode == MODE_CURRENT),
      .below(!ana.current_above),
      .expired(filt_done)
   );
   always_comb
   begin
      state_d = state_q;
      recharge_d = recharge_q;
      timer_d = timer_q;
      trickle_d = trickle_q;
      if (shutdown)
      begin
         state_d = ST_OFF;
         recharge_d = 1'b0;
         timer_d = '0;
         trickle_d = '0;
      end
      else
      begin
         case (state_q)
            ST_OFF:
               state_d = ST_CHECK;
            ST_CHECK:
            begin
               timer_d = '0;
               trickle_d = '0;
               recharge_d = 1'b0;
               if (mode == MODE_USER)
                  state_d = ST_CHARGE;
               else if (ana.bat_above_rechg)
                  state_d = ST_STANDBY;
               else
                  state_d = ST_CHARGE;
            end
            ST_CHARGE:
            begin
               if (use_timer)
               begin
                  timer_d = timer_q + 40'd1;
                  if (ana.trickle)
                     trickle_d = trickle_q + 40'd1;
               end
               if (trickle_over && ana.trickle)
                  state_d = ST_FAULT;
               else if (timer_done)
                  state_d = ST_STANDBY;
               else if (filt_done)
                  state_d = ST_STANDBY;
            end
            ST_STANDBY:
            begin
               if (mode != MODE_USER && !ana.bat_above_rechg)
               begin
                  state_d = ST_CHARGE;
                  recharge_d = 1'b1;
                  timer_d = '0;
                  trickle_d = '0;
               end
            end
            ST_FAULT:
               state_d = ST_FAULT;
            default:
               state_d = ST_OFF;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_OFF;
         recharge_q <= 1'b0;
         timer_q <= '0;
         trickle_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         recharge_q <= recharge_d;
         timer_q <= timer_d;
         trickle_q <= trickle_d;
      end
   end
   // ****************************************
   // Fault blink
   // ****************************************
   logic [31:0] blink_cnt_q;
   logic blink_q;
   wire logic blink_wrap = (blink_cnt_q >= 32'(BLINK_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
      end
      else if (state_q != ST_FAULT)
      begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
      end
      else if (blink_wrap)
      begin
         blink_cnt_q <= '0;
         blink_q <= !blink_q;
      end
      else
         blink_cnt_q <= blink_cnt_q + 32'd1;
   end
   // ****************************************
   // Status output (oe_n low pulls pin low)
   // ****************************************
   wire logic low_by_current = det_open || ana.current_above ||
                               !ana.cv_mode;
   logic pull_low;
   assign pull_low = (state_q == ST_FAULT) ? !blink_q :
                     !charging ? 1'b0 :
                     (mode == MODE_CURRENT) ? 1'b1 :
                     low_by_current;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         charge_status_out_oe_n <= 1'b1;
         charge_status_out_o <= 1'b0;
         charging_on <= 1'b0;
      end
      else
      begin
         charge_status_out_oe_n <= !pull_low;
         charge_status_out_o <= 1'b0;
         charging_on <= charging;
      end
   end
   // ****************************************
   // Events and interrupt
   // ****************************************
   wire logic ev_done = charging && state_d == ST_STANDBY;
   wire logic ev_fault = charging && state_d == ST_FAULT;
   wire logic ev_rechg = (state_q == ST_STANDBY) && state_d == ST_CHARGE;
   wire logic [IRQ_WIDTH-1:0] events = {ev_rechg, ev_fault, ev_done};
   wire logic [IRQ_WIDTH-1:0] w1c = (wr && hit_istat) ?
                                    pwdata[IRQ_WIDTH-1:0] : '0;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_q <= '0;
      else
         irq_stat_q <= (irq_stat_q & ~w1c) | events;
   end
   // ****************************************
   // APB slave
   // ****************************************
   logic [31:0] rd_mux;
   assign rd_mux = hit_ctrl ? ctrl_q :
                   hit_stat ? {24'h0000_00, 1'b0, state_q, 1'b0,
                               mode, charging} :
                   hit_istat ? 32'(irq_stat_q) :
                   hit_imask ? 32'(irq_mask_q) :
                   hit_time ? time_q[31:0] :
                   hit_elap ? elapsed_q[31:0] : 32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= CTRL_RESET;
         irq_mask_q <= IRQ_MASK_RESET;
         time_q <= '0;
         elapsed_q <= '0;
      end
      else
      begin
         if (time_q == 40'd0)
            time_q <= CHARGE_CYCLES;
         if (wr && hit_ctrl)
            ctrl_q <= pwdata & 32'h0000_0003;
         if (wr && hit_imask)
            irq_mask_q <= pwdata[IRQ_WIDTH-1:0];
         if (wr && hit_time && pwdata != 32'h0000_0000)
            time_q <= {8'h00, pwdata};
         elapsed_q <= timer_q;
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !mapped;
         prdata_q <= (psel && !penable && !pwrite) ? rd_mux : prdata_q;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   // ****************************************
   // Checks
   // ****************************************
   AST_SHUTDOWN: assert property (@(posedge pclk)
      disable iff (!presetn) shutdown |=> state_q == ST_OFF)
      else $error("Shutdown did not force off state");
   AST_USER_NOCHECK: assert property (@(posedge pclk)
      disable iff (!presetn)
      (state_q == ST_CHECK && !shutdown && mode == MODE_USER)
      |=> state_q == ST_CHARGE)
      else $error("User mode did not start charging");
   AST_SMART: assert property (@(posedge pclk)
      disable iff (!presetn)
      (state_q == ST_CHECK && !shutdown && mode != MODE_USER &&
       ana.bat_above_rechg) |=> state_q == ST_STANDBY)
      else $error("High battery did not enter standby");
   AST_NO_AUTO_USER: assert property (@(posedge pclk)
      disable iff (!presetn)
      (state_q == ST_STANDBY && mode == MODE_USER && !shutdown)
      |=> state_q == ST_STANDBY)
      else $error("User mode restarted automatically");
   AST_TIMER_END: assert property (@(posedge pclk)
      disable iff (!presetn)
      (charging && use_timer && timer_q >= limit_t && !shutdown &&
       !(trickle_over && ana.trickle)) |=> state_q == ST_STANDBY)
      else $error("Timer expiry did not stop charging");
   AST_CUR_LOW: assert property (@(posedge pclk)
      disable iff (!presetn)
      (charging && mode == MODE_CURRENT) |=> !charge_status_out_oe_n)
      else $error("Status not low while charging in current mode");
   AST_IDLE_HIZ: assert property (@(posedge pclk)
      disable iff (!presetn)
      (state_q == ST_STANDBY) |=> charge_status_out_oe_n)
      else $error("Status not released after charge end");
   AST_NO_TIMER: assert property (@(posedge pclk)
      disable iff (!presetn)
      (mode == MODE_CURRENT && charging && !shutdown)
      |=> timer_q == $past(timer_q))
      else $error("Timer ran in current mode");
   AST_FILTER: assert property (@(posedge pclk)
      disable iff (!presetn)
      (charging && mode == MODE_CURRENT && ana.current_above && !shutdown)
      |=> state_q == ST_CHARGE)
      else $error("Charge ended while current above threshold");
endmodule
`default_nettype wire

// ==== tb/battery_model.sv ====
// Model of the analog charge path and the status LED
`timescale 1ns/1ps
`default_nettype none
module battery_model
   import chg_term_pkg::*;
(
   input wire logic charging_on,
   input wire logic cur_low,
   input wire logic trickle_req,
   input wire logic bat_high,
   input wire logic oe_n,
   input wire logic o,
   output var analog_s analog_out,
   output logic led_on
);
   // ****************************************
   // Comparators and open-drain pin
   // ****************************************
   wire logic trickle_now = trickle_req & charging_on;
   wire logic pin_level = oe_n ? 1'b1 : o;
   // Low current is only seen in constant-voltage operation
   assign analog_out = {~cur_low, cur_low, trickle_now, bat_high};
   // Pull-up on the pin, LED lit while pulled low
   assign led_on = ~pin_level;
endmodule
`default_nettype wire

// ==== tb/charge_termination_control_tb.sv ====
// Testbench of the charge termination control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module charge_termination_control_tb
   import chg_term_pkg::*;
;
   localparam int CHG_CYC = 1000;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic charger_enable_pin = 1'b1;
   logic timer_sel_gnd = 1'b0;
   logic timer_sel_vcc = 1'b0;
   analog_s analog_in;
   logic oe_n;
   logic out_o;
   logic charging_on;
   logic cur_low = 1'b0;
   logic trickle_req = 1'b0;
   logic bat_high = 1'b0;
   logic led_on;
   logic prev_on = 1'b0;
   logic [31:0] rdata;
   logic perr;
   int len = 0;
   int fail_count = 0;
   int samples_checked = 0;
   int n;
   int tog;
   logic last;
   // ****************************************
   // Design, partner and clock
   // ****************************************
   charge_termination_control #(.CHARGE_CYCLES(40'(CHG_CYC)),
      .FILTER_CYCLES(10), .BLINK_CYCLES(4)) i_charge_termination_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq),
      .charger_enable_pin(charger_enable_pin),
      .timer_sel_gnd(timer_sel_gnd), .timer_sel_vcc(timer_sel_vcc),
      .analog_in(analog_in), .charge_status_out_oe_n(oe_n),
      .charge_status_out_o(out_o), .charging_on(charging_on));
   battery_model i_battery_model (.charging_on(charging_on),
      .cur_low(cur_low), .trickle_req(trickle_req), .bat_high(bat_high),
      .oe_n(oe_n), .o(out_o), .analog_out(analog_in), .led_on(led_on));
   always #20 pclk = ~pclk;
   // Length of the last charge run in cycles
   always @(posedge pclk)
   begin
      prev_on <= charging_on;
      if (charging_on && !prev_on)
         len <= 1;
      else if (charging_on)
         len <= len + 1;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task finish_test;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rdata = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
      if (k >= 20)
         `CHK(pready, 1'b1);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v);
      xfer(1'b1, a, v);
   endtask
   task rd(input logic [11:0] a);
      xfer(1'b0, a, 32'h0000_0000);
   endtask
   task cyc(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   task wt(input logic v, input int lim);
      n = 0;
      while (charging_on !== v && n < lim)
      begin
         cyc(1);
         n++;
      end
      if (n >= lim)
         `CHK(charging_on, v);
   endtask
   task start;
      @(posedge pclk) charger_enable_pin <= 1'b0;
   endtask
   task stop;
      @(posedge pclk) charger_enable_pin <= 1'b1;
      wt(1'b0, 10);
      cyc(5);
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      finish_test;
   end
   initial
   begin
      cyc(4);
      @(posedge pclk) presetn <= 1'b1;
      `CHK(oe_n, 1'b1);
      rd(OFS_CTRL);
      `CHK(rdata, CTRL_RESET);
      rd(OFS_IRQ_MASK);
      `CHK(rdata, 32'h0000_0000);
      wr(OFS_CHG_TIME, 32'h0000_0000);
      rd(OFS_CHG_TIME);
      `CHK(rdata, CHG_CYC);
      rd(12'h020);
      `CHK(perr, 1'b1);
      `CHK(rdata, 32'h0000_0000);
      // Time termination, full cycle
      start;
      wt(1'b1, 50);
      cyc(10);
      `CHK(oe_n, 1'b0);
      rd(OFS_ELAPSED);
      `CHK(rdata >= 10 && rdata <= 20, 1'b1);
      @(posedge pclk) cur_low <= 1'b1;
      cyc(6);
      `CHK({charging_on, oe_n}, 2'b11);
      @(posedge pclk) cur_low <= 1'b0;
      bat_high <= 1'b1;
      wt(1'b0, 1100);
      `CHK(len >= CHG_CYC - 5 && len <= CHG_CYC + 5, 1'b1);
      cyc(3);
      `CHK(oe_n, 1'b1);
      rd(OFS_STATUS);
      `CHK(rdata[6:4], ST_STANDBY);
      rd(OFS_IRQ_STAT);
      `CHK({irq, rdata[IRQ_DONE_BIT]}, 2'b01);
      wr(OFS_IRQ_MASK, 32'h0000_0007);
      cyc(3);
      `CHK(irq, 1'b1);
      wr(OFS_IRQ_STAT, 32'h0000_0007);
      cyc(3);
      `CHK(irq, 1'b0);
      // Automatic recharge at half time
      @(posedge pclk) bat_high <= 1'b0;
      wt(1'b1, 20);
      @(posedge pclk) bat_high <= 1'b1;
      wt(1'b0, 600);
      `CHK(len >= CHG_CYC / 2 - 5 && len <= CHG_CYC / 2 + 5, 1'b1);
      rd(OFS_IRQ_STAT);
      `CHK(rdata[IRQ_RECHG_BIT], 1'b1);
      // Shutdown mid-charge, then start with a full battery
      stop;
      @(posedge pclk) bat_high <= 1'b0;
      start;
      wt(1'b1, 50);
      cyc(50);
      stop;
      rd(OFS_STATUS);
      `CHK(rdata[6:4], ST_OFF);
      @(posedge pclk) bat_high <= 1'b1;
      start;
      cyc(30);
      rd(OFS_STATUS);
      `CHK({charging_on, rdata[6:4]}, {1'b0, ST_STANDBY});
      stop;
      // Detect pin open
      wr(OFS_CTRL, 32'h0000_0003);
      @(posedge pclk) bat_high <= 1'b0;
      cur_low <= 1'b1;
      start;
      wt(1'b1, 50);
      @(posedge pclk) bat_high <= 1'b1;
      cyc(20);
      `CHK(oe_n, 1'b0);
      wt(1'b0, 1100);
      cyc(3);
      `CHK(oe_n, 1'b1);
      stop;
      wr(OFS_CTRL, CTRL_RESET);
      // Long trickle gives a blinking fault
      @(posedge pclk) bat_high <= 1'b0;
      cur_low <= 1'b0;
      trickle_req <= 1'b1;
      start;
      wt(1'b1, 50);
      wt(1'b0, 400);
      `CHK(len >= CHG_CYC / 4 - 5 && len <= CHG_CYC / 4 + 5, 1'b1);
      rd(OFS_IRQ_STAT);
      `CHK(rdata[IRQ_FAULT_BIT], 1'b1);
      tog = 0;
      last = led_on;
      repeat (40)
      begin
         cyc(1);
         if (led_on !== last)
            tog++;
         last = led_on;
      end
      `CHK(tog >= 9 && tog <= 11, 1'b1);
      @(posedge pclk) trickle_req <= 1'b0;
      stop;
      `CHK(led_on, 1'b0);
      // Current termination with a short dip
      @(posedge pclk) timer_sel_gnd <= 1'b1;
      cyc(5);
      start;
      wt(1'b1, 50);
      @(posedge pclk) bat_high <= 1'b1;
      cyc(CHG_CYC + 200);
      rd(OFS_STATUS);
      `CHK({charging_on, oe_n, rdata[2:1]}, 4'b1001);
      @(posedge pclk) cur_low <= 1'b1;
      repeat (6) @(posedge pclk);
      cur_low <= 1'b0;
      cyc(20);
      `CHK(charging_on, 1'b1);
      @(posedge pclk) cur_low <= 1'b1;
      wt(1'b0, 40);
      `CHK(n >= 10 && n <= 18, 1'b1);
      cyc(2);
      `CHK(oe_n, 1'b1);
      stop;
      @(posedge pclk) timer_sel_gnd <= 1'b0;
      cur_low <= 1'b0;
      // User termination
      timer_sel_vcc <= 1'b1;
      cyc(5);
      start;
      wt(1'b1, 20);
      cyc(CHG_CYC + 200);
      rd(OFS_STATUS);
      `CHK({charging_on, oe_n, rdata[2:1]}, 4'b1010);
      @(posedge pclk) cur_low <= 1'b1;
      cyc(6);
      `CHK(oe_n, 1'b1);
      stop;
      rd(OFS_STATUS);
      `CHK(rdata[6:4], ST_OFF);
      finish_test;
   end
endmodule
`default_nettype wire
